/* dma_layout_pkg.sv */
// constants and carriers for the defect region layout and descriptor block
// assumes one clock domain shared with the drive control logic
`default_nettype none
package dma_layout_pkg;
  localparam logic [31:0] PAD_SECTORS = 32'h0000_0003;
  localparam logic [31:0] PAD_GAP = 32'h0000_0002;
  localparam logic [31:0] MIN_SIZE = 32'h0000_0001;
  localparam logic [31:0] NO_START = 32'h7FFF_FFFF;
  localparam logic [15:0] MARKER_HEAD = 16'hA5A5;
  localparam logic [15:0] MARKER_TAIL = 16'h5A5A;
  localparam logic [7:0] FLAG_VALID = 8'h01;
  localparam logic [7:0] FLAG_INVALID = 8'h00;
  localparam logic [7:0] SDL_GROUP = 8'hFA;
  localparam logic [5:0] DIV_STEPS = 6'h20;
  localparam logic [12:0] HDR_BYTES = 13'h0090;
  localparam int HDR_BITS = 1152;
  localparam logic [12:0] OFS_HEAD = 13'h0000;
  localparam logic [12:0] OFS_A_START = 13'h0023;
  localparam logic [12:0] OFS_TAIL = 13'h1FFE;
  localparam logic [12:0] OFS_TAIL_LO = 13'h1FFF;
  localparam logic [1:0] COPY_A = 2'h0;
  localparam logic [1:0] COPY_B = 2'h1;
  localparam logic [1:0] COPY_X = 2'h2;
  localparam logic [1:0] COPY_NONE = 2'h3;

  typedef enum logic [1:0] {P_IDLE, P_DIVB, P_DIVS, P_ASSIGN} phase_e;

  typedef struct packed {
    logic [31:0] first;
    logic [31:0] last;
  } area_s;

  typedef struct packed {
    area_s span;
    logic [7:0] flag;
    logic [127:0] good_map;
  } copy_s;

  typedef struct packed {
    area_s list_a;
    area_s secondary_defect_list;
    area_s primary_spare_sub_area;
    area_s secondary_spare_sub_area;
    area_s dup;
    area_s list_b;
  } layout_s;

  // field order is the byte order of the descriptor, most significant first
  typedef struct packed {
    logic [15:0] head;
    logic [7:0] rev;
    logic [223:0] id_text;
    logic [31:0] serial;
    copy_s list_a;
    area_s secondary_defect_list;
    logic [15:0] sdl_max;
    area_s primary_spare_sub_area;
    area_s secondary_spare_sub_area;
    area_s dup;
    copy_s list_b;
    copy_s list_x;
  } dds_s;
endpackage
`default_nettype wire

/* dma_layout.sv */
// defect region layout engine, descriptor sector builder and parser
// assumes sizing inputs stay stable from start_i until done_o
//
// Summary of operation
// - order: copy A, secondary list, spares, secondary spares, duplicates, copy B; pads before three
// - copy A size is sectors used writing it, at least one
// - copy B size is twice ceiling of defects over entries per page
// - copy B is one sector when uncertified or no defects found
// - secondary list size is twice ceiling of leftover space over entries per page
// - on write-once media a list page is due every 250 spare writes
// - full secondary list also needs a scan of unrecorded spare sectors
// - duplicate pages hold the secondary list and match its size
// - estimated spare size is user defects; actual grows by spare-area defects
// - no user defects still gives the primary spares one sector
// - secondary spares take all remaining region space
// - copies A, B and external hold the list; any may recover
// - descriptor is exactly one sector with all locations and list data
// - marker A5A5 at bytes 0-1, complement 5A5A at bytes 8190-8191
// - copy A start, end, flag and bitmap at bytes 35-59
// - secondary list start, end and page entries at bytes 60-69
// - spare, secondary spare and duplicate extents at bytes 70-93
// - copy B start, end, flag and bitmap at bytes 94-118
// - external copy start, end, flag and bitmap at bytes 119-143
// - revision, id text, serial at bytes 2-34; bytes 144-8189 unspecified
// - stored extents point at first and last good sectors used
// - failed first page gives start 7FFFFFFF and a cleared flag
// - validity flag is one when valid, zero when not, nothing else
// - bitmap bit set marks a good list sector, clear marks bad
`timescale 1ns/100ps
`default_nettype none
module dma_layout
  import dma_layout_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [31:0] region_start_i,
  input wire logic [31:0] region_size_i,
  input wire logic [31:0] list_a_used_i,
  input wire logic [31:0] primary_defects_i,
  input wire logic [31:0] user_zone_defects_i,
  input wire logic [31:0] spare_zone_defects_i,
  input wire logic [15:0] pdl_entries_i,
  input wire logic [15:0] sdl_entries_i,
  input wire logic certified_i,
  input wire logic worm_i,
  input wire logic spare_write_i,
  input wire logic [31:0] spares_recorded_i,
  input wire logic [31:0] list_a_skip_i,
  input wire logic list_a_fail_i,
  input wire logic [31:0] list_b_skip_i,
  input wire logic list_b_fail_i,
  input wire area_s list_x_i,
  input wire logic list_x_fail_i,
  input wire logic [127:0] map_a_i,
  input wire logic [127:0] map_b_i,
  input wire logic [127:0] map_x_i,
  input wire logic [7:0] format_rev_i,
  input wire logic [223:0] id_text_i,
  input wire logic [31:0] serial_i,
  input wire logic rd_en_i,
  input wire logic [12:0] rd_addr_i,
  input wire logic wr_en_i,
  input wire logic [12:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_last_i,
  output logic busy_o,
  output logic done_o,
  output logic layout_err_o,
  output var layout_s layout_o,
  output logic sdl_page_due_o,
  output logic scan_needed_o,
  output logic [31:0] scan_first_o,
  output logic [7:0] rd_data_o,
  output logic parse_ok_o,
  output logic parse_err_o,
  output var dds_s rx_dds_o,
  output logic [1:0] recover_copy_o
);

  typedef struct packed {
    phase_e phase;
    logic [31:0] div_rem;
    logic [31:0] div_quo;
    logic [31:0] div_num;
    logic [5:0] div_cnt;
    logic [31:0] a_size;
    logic [31:0] b_size;
    logic [31:0] psa_est;
    logic [31:0] psa_size;
    logic [31:0] sdl_size;
    layout_s lay;
    logic done;
    logic busy;
    logic err;
    logic [7:0] grp_cnt;
    logic page_due;
    logic [31:0] spares_used;
    logic scan_needed;
    logic [31:0] scan_first;
    logic [7:0] rd_data;
    dds_s rx;
    logic [15:0] rx_tail;
    logic parse_ok;
    logic parse_err;
    logic [1:0] rec_copy;
  } st_s;

  st_s st_r;
  st_s st_nxt;
  dds_s tx;
  logic [32:0] div_try;
  logic [31:0] div_den;
  logic [31:0] ceil_q;
  logic [33:0] overhead;
  logic [34:0] used_all;
  logic [31:0] sdl_num;
  logic head_ok;
  logic tail_ok;
  logic flags_ok;

  // descriptor image, assembled from the live layout and the drive data
  always_comb begin
    tx = '0;
    tx.head = MARKER_HEAD;
    tx.rev = format_rev_i;
    tx.id_text = id_text_i;
    tx.serial = serial_i;
    tx.list_a.span.first = list_a_fail_i ? NO_START : st_r.lay.list_a.first + list_a_skip_i;
    tx.list_a.span.last = st_r.lay.list_a.last;
    tx.list_a.flag = list_a_fail_i ? FLAG_INVALID : FLAG_VALID;
    tx.list_a.good_map = map_a_i;
    tx.secondary_defect_list = st_r.lay.secondary_defect_list;
    tx.sdl_max = sdl_entries_i;
    tx.primary_spare_sub_area = st_r.lay.primary_spare_sub_area;
    tx.secondary_spare_sub_area = st_r.lay.secondary_spare_sub_area;
    tx.dup = st_r.lay.dup;
    tx.list_b.span.first = list_b_fail_i ? NO_START : st_r.lay.list_b.first + list_b_skip_i;
    tx.list_b.span.last = st_r.lay.list_b.last;
    tx.list_b.flag = list_b_fail_i ? FLAG_INVALID : FLAG_VALID;
    tx.list_b.good_map = map_b_i;
    tx.list_x.span.first = list_x_fail_i ? NO_START : list_x_i.first;
    tx.list_x.span.last = list_x_i.last;
    tx.list_x.flag = list_x_fail_i ? FLAG_INVALID : FLAG_VALID;
    tx.list_x.good_map = map_x_i;
  end

  assign div_den = (st_r.phase == P_DIVB) ? ((pdl_entries_i == '0) ? MIN_SIZE : {16'h0000, pdl_entries_i})
                                          : ((sdl_entries_i == '0) ? MIN_SIZE : {16'h0000, sdl_entries_i});
  assign div_try = {st_r.div_rem, st_r.div_num[31]};
  assign ceil_q = st_r.div_quo + {31'h0000_0000, st_r.div_rem != '0};
  // pad sectors are charged before the secondary list is sized
  assign overhead = {2'b00, st_r.a_size} + {2'b00, st_r.b_size} + {2'b00, st_r.psa_est} + {2'b00, PAD_SECTORS};
  assign sdl_num = ({2'b00, region_size_i} > overhead) ? 32'(({2'b00, region_size_i} - overhead)) : '0;
  assign used_all = {3'b000, st_r.a_size} + {3'b000, st_r.sdl_size} + {3'b000, st_r.psa_size}
                  + {3'b000, st_r.sdl_size} + {3'b000, st_r.b_size} + {3'b000, PAD_SECTORS};
  assign head_ok = st_r.rx.head == MARKER_HEAD;
  assign tail_ok = st_r.rx_tail == MARKER_TAIL;
  assign flags_ok = (st_r.rx.list_a.flag <= FLAG_VALID) && (st_r.rx.list_b.flag <= FLAG_VALID)
                 && (st_r.rx.list_x.flag <= FLAG_VALID);

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.page_due = 1'b0;
    st_nxt.parse_ok = 1'b0;
    st_nxt.parse_err = 1'b0;
    if (st_r.div_cnt != '0) begin
      if (div_try >= {1'b0, div_den}) begin
        st_nxt.div_rem = 32'(div_try - {1'b0, div_den});
        st_nxt.div_quo = {st_r.div_quo[30:0], 1'b1};
      end else begin
        st_nxt.div_rem = div_try[31:0];
        st_nxt.div_quo = {st_r.div_quo[30:0], 1'b0};
      end
      st_nxt.div_num = {st_r.div_num[30:0], 1'b0};
      st_nxt.div_cnt = st_r.div_cnt - 6'h01;
    end
    unique case (st_r.phase)
      P_IDLE: begin
        if (start_i) begin
          st_nxt.a_size = (list_a_used_i == '0) ? MIN_SIZE : list_a_used_i;
          st_nxt.psa_est = (user_zone_defects_i == '0) ? MIN_SIZE : user_zone_defects_i;
          st_nxt.psa_size = ((user_zone_defects_i == '0) ? MIN_SIZE : user_zone_defects_i)
                          + spare_zone_defects_i;
          st_nxt.div_rem = '0;
          st_nxt.div_quo = '0;
          st_nxt.div_num = primary_defects_i;
          st_nxt.div_cnt = DIV_STEPS;
          st_nxt.err = 1'b0;
          st_nxt.phase = P_DIVB;
        end
      end
      P_DIVB: begin
        if (st_r.div_cnt == '0) begin
          // uncertified media records an empty list in a single sector
          if (!certified_i || primary_defects_i == '0) begin
            st_nxt.b_size = MIN_SIZE;
          end else begin
            st_nxt.b_size = {ceil_q[30:0], 1'b0};
          end
          st_nxt.div_cnt = DIV_STEPS + 6'h01;
          st_nxt.phase = P_DIVS;
        end
      end
      P_DIVS: begin
        if (st_r.div_cnt == DIV_STEPS + 6'h01) begin
          // load cycle: b_size is settled now, so the step above is thrown away
          st_nxt.div_rem = '0;
          st_nxt.div_quo = '0;
          st_nxt.div_num = sdl_num;
          st_nxt.div_cnt = DIV_STEPS;
        end else if (st_r.div_cnt == '0) begin
          st_nxt.sdl_size = (ceil_q == '0) ? MIN_SIZE : {ceil_q[30:0], 1'b0};
          st_nxt.phase = P_ASSIGN;
        end
      end
      P_ASSIGN: begin
        st_nxt.lay.list_a.first = region_start_i;
        st_nxt.lay.list_a.last = region_start_i + st_r.a_size - MIN_SIZE;
        st_nxt.lay.secondary_defect_list.first = region_start_i + st_r.a_size;
        st_nxt.lay.secondary_defect_list.last = region_start_i + st_r.a_size + st_r.sdl_size - MIN_SIZE;
        st_nxt.lay.primary_spare_sub_area.first = st_nxt.lay.secondary_defect_list.last + PAD_GAP;
        st_nxt.lay.primary_spare_sub_area.last = st_nxt.lay.primary_spare_sub_area.first + st_r.psa_size - MIN_SIZE;
        st_nxt.lay.secondary_spare_sub_area.first = st_nxt.lay.primary_spare_sub_area.last + PAD_GAP;
        st_nxt.lay.secondary_spare_sub_area.last = region_start_i + region_size_i - st_r.b_size - st_r.sdl_size - PAD_GAP;
        st_nxt.lay.dup.first = st_nxt.lay.secondary_spare_sub_area.last + PAD_GAP;
        st_nxt.lay.dup.last = st_nxt.lay.dup.first + st_r.sdl_size - MIN_SIZE;
        st_nxt.lay.list_b.first = st_nxt.lay.dup.last + MIN_SIZE;
        st_nxt.lay.list_b.last = region_start_i + region_size_i - MIN_SIZE;
        // no room left for even one secondary spare
        st_nxt.err = used_all >= {3'b000, region_size_i};
        st_nxt.done = 1'b1;
        st_nxt.phase = P_IDLE;
      end
    endcase
    st_nxt.busy = st_nxt.phase != P_IDLE;
    if (spare_write_i) begin
      st_nxt.spares_used = st_r.spares_used + MIN_SIZE;
      if (worm_i) begin
        if (st_r.grp_cnt == SDL_GROUP - 8'h01) begin
          st_nxt.grp_cnt = '0;
          st_nxt.page_due = 1'b1;
        end else begin
          st_nxt.grp_cnt = st_r.grp_cnt + 8'h01;
        end
      end
    end
    // spares past the recorded ones must be scanned to complete the list
    st_nxt.scan_needed = st_r.spares_used > spares_recorded_i;
    st_nxt.scan_first = st_r.lay.secondary_spare_sub_area.first + spares_recorded_i;
    if (rd_en_i) begin
      if (rd_addr_i < HDR_BYTES) begin
        st_nxt.rd_data = tx[HDR_BITS - 1 - 8 * int'(rd_addr_i) -: 8];
      end else if (rd_addr_i == OFS_TAIL) begin
        st_nxt.rd_data = MARKER_TAIL[15:8];
      end else if (rd_addr_i == OFS_TAIL_LO) begin
        st_nxt.rd_data = MARKER_TAIL[7:0];
      end else begin
        st_nxt.rd_data = '0;
      end
    end
    if (wr_en_i) begin
      if (wr_addr_i < HDR_BYTES) begin
        st_nxt.rx[HDR_BITS - 1 - 8 * int'(wr_addr_i) -: 8] = wr_data_i;
      end else if (wr_addr_i == OFS_TAIL) begin
        st_nxt.rx_tail[15:8] = wr_data_i;
      end else if (wr_addr_i == OFS_TAIL_LO) begin
        st_nxt.rx_tail[7:0] = wr_data_i;
      end
    end
    if (wr_last_i) begin
      // last byte must be written before wr_last_i; the check reads stored bytes
      st_nxt.parse_ok = head_ok && tail_ok && flags_ok;
      st_nxt.parse_err = !(head_ok && tail_ok && flags_ok);
      if (st_r.rx.list_a.flag == FLAG_VALID) begin
        st_nxt.rec_copy = COPY_A;
      end else if (st_r.rx.list_b.flag == FLAG_VALID) begin
        st_nxt.rec_copy = COPY_B;
      end else if (st_r.rx.list_x.flag == FLAG_VALID) begin
        st_nxt.rec_copy = COPY_X;
      end else begin
        st_nxt.rec_copy = COPY_NONE;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
      st_r.phase <= P_IDLE;
      st_r.rec_copy <= COPY_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_o = st_r.busy;
  assign done_o = st_r.done;
  assign layout_err_o = st_r.err;
  assign layout_o = st_r.lay;
  assign sdl_page_due_o = st_r.page_due;
  assign scan_needed_o = st_r.scan_needed;
  assign scan_first_o = st_r.scan_first;
  assign rd_data_o = st_r.rd_data;
  assign parse_ok_o = st_r.parse_ok;
  assign parse_err_o = st_r.parse_err;
  assign rx_dds_o = st_r.rx;
  assign recover_copy_o = st_r.rec_copy;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_pad_order;
    done_o |-> (layout_o.primary_spare_sub_area.first == layout_o.secondary_defect_list.last + PAD_GAP) && (layout_o.secondary_defect_list.first == layout_o.list_a.last + 1);
  endproperty
  a_pad_order: assert property (p_pad_order) else $error("sub-area order or pad wrong");
  property p_b_single;
    (st_r.phase == P_DIVB && st_r.div_cnt == '0 && !certified_i) |=> st_r.b_size == MIN_SIZE;
  endproperty
  a_b_single: assert property (p_b_single) else $error("copy B not one sector when uncertified");
  property p_dup_size;
    done_o |-> (layout_o.dup.last - layout_o.dup.first) == (layout_o.secondary_defect_list.last - layout_o.secondary_defect_list.first);
  endproperty
  a_dup_size: assert property (p_dup_size) else $error("duplicate size differs from list size");
  property p_psa_min;
    done_o |-> layout_o.primary_spare_sub_area.last >= layout_o.primary_spare_sub_area.first;
  endproperty
  a_psa_min: assert property (p_psa_min) else $error("primary spares below one sector");
  property p_region_end;
    done_o |-> layout_o.list_b.last == $past(region_start_i) + $past(region_size_i) - MIN_SIZE;
  endproperty
  a_region_end: assert property (p_region_end) else $error("layout does not fill region");
  property p_head_byte;
    rd_en_i && rd_addr_i == OFS_HEAD ##1 1'b1 |-> rd_data_o == MARKER_HEAD[15:8];
  endproperty
  a_head_byte: assert property (p_head_byte) else $error("leading marker byte wrong");
  property p_fail_start;
    rd_en_i && rd_addr_i == OFS_A_START && list_a_fail_i |=> rd_data_o == NO_START[31:24];
  endproperty
  a_fail_start: assert property (p_fail_start) else $error("failed copy start not marked");
  property p_parse;
    parse_ok_o |-> $past(head_ok) && $past(tail_ok) && !parse_err_o;
  endproperty
  a_parse: assert property (p_parse) else $error("sector accepted with bad markers");
  property p_group;
    sdl_page_due_o |-> $past(worm_i) && $past(spare_write_i) && st_r.grp_cnt == '0;
  endproperty
  a_group: assert property (p_group) else $error("list page due without a full group");
  property p_busy_bound;
    start_i && !busy_o |-> ##[60:80] done_o;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("layout not finished in time");

  c_done: cover property (done_o && !layout_err_o);
  c_parse_ok: cover property (parse_ok_o);
  c_parse_err: cover property (parse_err_o);
  c_page_due: cover property (sdl_page_due_o);
endmodule
`default_nettype wire

/* sector_host_model.sv */
// drive controller model: reads the descriptor sector back and writes it into the parser
// assumes one clock shared with the layout block; drives just after rising edges
`timescale 1ns/100ps
`default_nettype none
module sector_host_model
  import dma_layout_pkg::*;
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [1:0] spoil_i,
  input wire logic [7:0] rd_data_i,
  output logic rd_en_o,
  output logic [12:0] rd_addr_o,
  output logic wr_en_o,
  output logic [12:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic wr_last_o
);
  logic [7:0] img [0:145];
  logic [12:0] loc;
  initial begin
    rd_en_o = 1'b0;
    rd_addr_o = 13'h0000;
    wr_en_o = 1'b0;
    wr_addr_o = 13'h0000;
    wr_data_o = 8'h00;
    wr_last_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        for (int i = 0; i < 146; i++) begin
          // header bytes, then the two trailing marker bytes
          loc = (i < 144) ? 13'(i) : 13'h1F6E + 13'(i);
          #1 rd_en_o = 1'b1;
          rd_addr_o = loc;
          @(posedge clk_i);
          #1 rd_en_o = 1'b0;
          img[i] = rd_data_i;
          rd_addr_o = ~loc;
          @(posedge clk_i);
        end
        // damage on request, as a bad medium read would
        case (spoil_i)
          2'h1: img[0] = img[0] ^ 8'h01;
          2'h2: img[145] = img[145] ^ 8'h01;
          2'h3: img[43] = 8'h02;
          default: ;
        endcase
        // leave the sampling edge before the first write is driven
        #1;
        for (int i = 0; i < 146; i++) begin
          wr_en_o = 1'b1;
          wr_addr_o = (i < 144) ? 13'(i) : 13'h1F6E + 13'(i);
          wr_data_o = img[i];
          @(posedge clk_i);
          #1;
        end
        wr_en_o = 1'b0;
        wr_data_o = ~wr_data_o;
        wr_last_o = 1'b1;
        @(posedge clk_i);
        #1 wr_last_o = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* dma_layout_tb.sv */
// bench for the defect region layout block: layout runs, spare tracking, descriptor read and parse
// assumes the package and the sector host model are compiled first
`timescale 1ns/100ps
`default_nettype none
module dma_layout_tb;
  import dma_layout_pkg::*;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, cert = 1'b1, worm = 1'b1, spw = 1'b0, t_rd = 1'b0, go = 1'b0;
  logic a_fail = 1'b0, b_fail = 1'b0, x_fail = 1'b0;
  logic [31:0] r_start = 32'h0000_03E8, r_size = 32'h0000_07D0, a_used = 32'h0000_0002, defects = 32'h0000_000A;
  logic [31:0] user_d = 32'h0000_000A, spare_d = 32'h0000_0002, recd = 32'h0000_0000, a_skip = 32'h0000_0000;
  logic [31:0] b_skip = 32'h0000_0001, serial = 32'h1234_5678, scan_first;
  logic [15:0] pdl_n = 16'h0004, sdl_n = 16'h0064;
  logic [12:0] t_addr = 13'h0000, m_addr, m_waddr;
  logic [7:0] rev = 8'h07, rd_data, m_wdata;
  logic [1:0] spoil = 2'h0, rcopy;
  logic [127:0] map_a = {8'h9C, 120'h0}, map_b = {8'h3C, 120'h0}, map_x = {8'hFF, 120'h0};
  logic [223:0] id_text = {8'h41, 216'h0};
  area_s ext = '{32'hC100_0000, 32'hC100_0003};
  logic m_rd, m_wr, m_last, busy, done, lerr, due, scan, p_ok, p_err;
  layout_s lay;
  dds_s rx;
  int fails = 0, check_count = 0, cyc;
  logic [12:0] addrs [20] = '{13'h0000, 13'h0001, 13'h0002, 13'h0003, 13'h001F, 13'h0023, 13'h0026, 13'h002B,
    13'h002C, 13'h0044, 13'h0045, 13'h005E, 13'h0061, 13'h0066, 13'h0067, 13'h0077, 13'h007F, 13'h00C8,
    13'h1FFE, 13'h1FFF};
  logic [7:0] exps [20] = '{8'hA5, 8'hA5, 8'h07, 8'h41, 8'h12, 8'h00, 8'hE8, 8'h01, 8'h9C, 8'h00, 8'h64, 8'h00,
    8'hB3, 8'h01, 8'h3C, 8'hC1, 8'h01, 8'h00, 8'h5A, 8'h5A};

  dma_layout dma_layout_i (.clk_i(clk), .sys_rst_i(rst), .start_i(start), .region_start_i(r_start),
    .region_size_i(r_size), .list_a_used_i(a_used), .primary_defects_i(defects), .user_zone_defects_i(user_d),
    .spare_zone_defects_i(spare_d), .pdl_entries_i(pdl_n), .sdl_entries_i(sdl_n), .certified_i(cert),
    .worm_i(worm), .spare_write_i(spw), .spares_recorded_i(recd), .list_a_skip_i(a_skip),
    .list_a_fail_i(a_fail), .list_b_skip_i(b_skip), .list_b_fail_i(b_fail), .list_x_i(ext),
    .list_x_fail_i(x_fail), .map_a_i(map_a), .map_b_i(map_b), .map_x_i(map_x), .format_rev_i(rev),
    .id_text_i(id_text), .serial_i(serial), .rd_en_i(t_rd | m_rd), .rd_addr_i(m_rd ? m_addr : t_addr),
    .wr_en_i(m_wr), .wr_addr_i(m_waddr), .wr_data_i(m_wdata), .wr_last_i(m_last), .busy_o(busy),
    .done_o(done), .layout_err_o(lerr), .layout_o(lay), .sdl_page_due_o(due), .scan_needed_o(scan),
    .scan_first_o(scan_first), .rd_data_o(rd_data), .parse_ok_o(p_ok), .parse_err_o(p_err), .rx_dds_o(rx),
    .recover_copy_o(rcopy));

  sector_host_model sector_host_model_i (.clk_i(clk), .go_i(go), .spoil_i(spoil), .rd_data_i(rd_data),
    .rd_en_o(m_rd), .rd_addr_o(m_addr), .wr_en_o(m_wr), .wr_addr_o(m_waddr), .wr_data_o(m_wdata),
    .wr_last_o(m_last));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_lay(input layout_s got, input layout_s exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // sizes in, sub-areas laid end to end with pads before spares, secondary spares and duplicates
  function automatic layout_s mk(input logic [31:0] a, s, p, b);
    layout_s l;
    logic [31:0] n, ss;
    ss = r_size - a - s - s - p - b - PAD_SECTORS;
    n = r_start;
    l.list_a = '{n, n + a - MIN_SIZE};
    n = n + a;
    l.secondary_defect_list = '{n, n + s - MIN_SIZE};
    n = n + s + MIN_SIZE;
    l.primary_spare_sub_area = '{n, n + p - MIN_SIZE};
    n = n + p + MIN_SIZE;
    l.secondary_spare_sub_area = '{n, n + ss - MIN_SIZE};
    n = n + ss + MIN_SIZE;
    l.dup = '{n, n + s - MIN_SIZE};
    n = n + s;
    l.list_b = '{n, n + b - MIN_SIZE};
    return l;
  endfunction

  // a second start in mid-run must be ignored
  task automatic run_layout(input logic [31:0] a, s, p, b, input logic e);
    @(posedge clk);
    #1 start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    cyc = 0;
    while (done !== 1'b1 && cyc < 200) begin
      @(posedge clk);
      #1 cyc++;
      start = (cyc == 10);
    end
    start = 1'b0;
    chk(cyc, 68);
    chk(busy, 1'b0);
    chk(lerr, e);
    if (!e) chk_lay(lay, mk(a, s, p, b));
    $display("layout test done");
  endtask

  task automatic rd(input logic [12:0] a);
    @(posedge clk);
    #1 t_rd = 1'b1;
    t_addr = a;
    @(posedge clk);
    #1 t_rd = 1'b0;
  endtask

  task automatic parse(input logic [1:0] s, input logic ok, input logic [1:0] copy);
    spoil = s;
    @(posedge clk);
    #1 go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    cyc = 0;
    while (p_ok !== 1'b1 && p_err !== 1'b1 && cyc < 1000) begin
      @(posedge clk);
      #1 cyc++;
    end
    chk(p_ok, ok);
    chk(p_err, !ok);
    if (ok) chk(rcopy, copy);
    if (ok) chk(rx.list_a.span.last, 32'h0000_03E9);
    $display("parse test done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk(rcopy, 2'h3);
    chk(done, 1'b0);
    run_layout(32'h0000_0002, 32'h0000_0028, 32'h0000_000C, 32'h0000_0006, 1'b0);
    cyc = 0;
    for (int i = 1; i <= 251; i++) begin
      @(posedge clk);
      #1 if (due === 1'b1) cyc = cyc + i - 1;
      spw = (i < 251);
      @(posedge clk);
      #1 spw = 1'b0;
      if (due === 1'b1) cyc = cyc + i;
    end
    chk(cyc, 250);
    chk(scan, 1'b1);
    chk(scan_first, 32'h0000_0420);
    recd = 32'h0000_00FA;
    repeat (2) @(posedge clk);
    #1 chk(scan, 1'b0);
    chk(scan_first, 32'h0000_051A);
    $display("spare test done");
    for (int i = 0; i < 20; i++) begin
      rd(addrs[i]);
      chk(rd_data, exps[i]);
    end
    $display("read test done");
    for (int s = 0; s < 4; s++) parse(2'(s), s == 0, 2'h0);
    a_fail = 1'b1;
    rd(13'h0023);
    chk(rd_data, 8'h7F);
    rd(13'h0026);
    chk(rd_data, 8'hFF);
    rd(13'h002B);
    chk(rd_data, 8'h00);
    parse(2'h0, 1'b1, 2'h1);
    cert = 1'b0;
    a_used = 32'h0000_0000;
    user_d = 32'h0000_0000;
    spare_d = 32'h0000_0000;
    run_layout(32'h0000_0001, 32'h0000_0028, 32'h0000_0001, 32'h0000_0001, 1'b0);
    r_size = 32'h0000_000A;
    run_layout(32'h0000_0001, 32'h0000_0002, 32'h0000_0001, 32'h0000_0001, 1'b1);
    complete_run();
  end

  // whole run needs about three thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
